/* design/dual_port_pixel_input.sv */
// Dual parallel pixel input ports with clock, enable and sync routing
// ********************************************************************
// Overview of operation
// - Each pixel write clock captures on rising or falling edge, set by software.
// - Each pixel write clock serves port 1, port 2 or both.
// - Data enables are active high and route to port 1, port 2 or both.
// - Channels are 10 bits; bit 9 weighs 128, bit 0 weighs 0.25.
// - Each port samples channels A, B and C together as one pixel.
// - Sync pairs serve their own port unless moved to the other port.
// - Dedicated frame, line and composite autolock syncs, separate from port syncs.
// ********************************************************************
`timescale 1ns/1ps
`include "pixin_defs.svh"

module dual_port_pixel_input #(
  parameter int FIFO_DEPTH  = `PIX_FIFO_DEPTH,
  parameter int SYNC_STAGES = `PIX_SYNC_STAGES
) (
  input  wire logic                                mclk,
  input  wire logic                                rst_n,
  input  wire logic                                pixel_write_clock_1,
  input  wire logic                                pixel_write_clock_2,
  input  wire logic                                pixel_write_clock_3,
  input  wire logic                                pixel_valid_1,
  input  wire logic                                pixel_valid_2,
  input  wire pixin_pkg::pixel_pins_type           port1_pins,
  input  wire pixin_pkg::pixel_pins_type           port2_pins,
  input  wire logic                                port1_frame_sync,
  input  wire logic                                port1_line_sync,
  input  wire logic                                port2_frame_sync,
  input  wire logic                                port2_line_sync,
  input  wire logic                                autolock_frame_sync,
  input  wire logic                                autolock_line_sync,
  input  wire logic                                autolock_composite_sync,
  input  wire logic [`PIX_CLOCKS-1:0]              clk_falling_edge,
  input  wire pixin_pkg::route_type                clk_route_1,
  input  wire pixin_pkg::route_type                clk_route_2,
  input  wire pixin_pkg::route_type                clk_route_3,
  input  wire pixin_pkg::route_type                valid_route_1,
  input  wire pixin_pkg::route_type                valid_route_2,
  input  wire logic [`PIX_PORTS-1:0]               sync_to_other,
  output pixin_pkg::pixel_word_type [`PIX_PORTS-1:0] pixel_out,
  output logic [`PIX_PORTS-1:0]                    pixel_out_valid,
  input  wire logic [`PIX_PORTS-1:0]               pixel_out_ready,
  output logic [`PIX_PORTS-1:0]                    port_clocked,
  output logic [`PIX_PORTS-1:0]                    overflow,
  input  wire logic [`PIX_PORTS-1:0]               overflow_clear,
  output pixin_pkg::autolock_type                  autolock_sync,
  output pixin_pkg::autolock_type                  autolock_rise
);
  import pixin_pkg::*;

  // ********************************************************************
  // Routing decode
  // ********************************************************************
  // True when a route setting includes port p (0 = port 1, 1 = port 2)
  function automatic logic serves_port(input route_type r, input int p);
    logic hit;
    hit = 1'b0;
    unique case (r)
      ROUTE_PORT1: hit = (p == 0);
      ROUTE_PORT2: hit = (p == 1);
      ROUTE_BOTH:  hit = 1'b1;
      default:     hit = 1'b0;
    endcase
    return hit;
  endfunction

  logic [`PIX_CLOCKS-1:0] raw_clk;
  route_type              clk_route [`PIX_CLOCKS];
  logic [`PIX_VALIDS-1:0] raw_valid;
  route_type              valid_route [`PIX_VALIDS];
  pixel_pins_type         pins [`PIX_PORTS];
  logic [`PIX_PORTS-1:0]  pair_frame;
  logic [`PIX_PORTS-1:0]  pair_line;

  assign raw_clk        = {pixel_write_clock_3, pixel_write_clock_2, pixel_write_clock_1};
  assign clk_route[0]   = clk_route_1;
  assign clk_route[1]   = clk_route_2;
  assign clk_route[2]   = clk_route_3;
  assign raw_valid      = {pixel_valid_2, pixel_valid_1};
  assign valid_route[0] = valid_route_1;
  assign valid_route[1] = valid_route_2;
  assign pins[0]        = port1_pins;
  assign pins[1]        = port2_pins;
  assign pair_frame     = {port2_frame_sync, port1_frame_sync};
  assign pair_line      = {port2_line_sync, port1_line_sync};

  // ********************************************************************
  // Per-port capture and crossing
  // ********************************************************************
  for (genvar p = 0; p < `PIX_PORTS; p++) begin : g_port
    logic [`PIX_CLOCKS-1:0]  clk_hit;
    logic [`PIX_CLOCKS-1:0]  clk_edge;
    logic                    link_clk;
    logic                    link_en;
    logic                    link_frame;
    logic                    link_line;
    logic [2:0]              lrst_s_r;
    logic                    lrst_n_r;
    logic                    cap_valid_r;
    pixel_word_type          cap_word_r;
    logic                    cap_ready;
    logic                    drop_tgl_r;
    logic [2:0]              drop_s_r;
    logic                    drop_seen;
    logic [2:0]              ack_s_r;
    logic                    drop_pend;
    logic                    ovf_r;
    logic                    ovf_nxt;
    pixel_word_type          fifo_word;

    for (genvar k = 0; k < `PIX_CLOCKS; k++) begin : g_clk
      assign clk_hit[k]  = serves_port(clk_route[k], p);
      // Inverting the pin makes the falling edge look like a rising one
      assign clk_edge[k] = raw_clk[k] ^ clk_falling_edge[k];
    end

    // Lowest-numbered clock wins when two serve the same port. The mux is
    // not glitch free: change routing or edge only while the source is idle.
    assign link_clk = clk_hit[0] ? clk_edge[0] :
                      clk_hit[1] ? clk_edge[1] :
                      clk_hit[2] ? clk_edge[2] : 1'b0;
    assign port_clocked[p] = |clk_hit;

    assign link_en = (serves_port(valid_route[0], p) && raw_valid[0]) ||
                     (serves_port(valid_route[1], p) && raw_valid[1]);

    // A pair moved away leaves its own port; both pairs may land on one port
    assign link_frame = ((sync_to_other[0] ? 1 : 0) == p && pair_frame[0]) ||
                        ((sync_to_other[1] ? 0 : 1) == p && pair_frame[1]);
    assign link_line  = ((sync_to_other[0] ? 1 : 0) == p && pair_line[0]) ||
                        ((sync_to_other[1] ? 0 : 1) == p && pair_line[1]);

    // Reset reaches the link side through its own synchroniser
    always_ff @(posedge link_clk) begin
      lrst_s_r <= {lrst_s_r[1:0], rst_n};
      if (lrst_s_r[1] == lrst_s_r[2]) begin
        lrst_n_r <= lrst_s_r[2];
      end
    end

    // Toggles closer than an mclk period would cancel out, so only one drop
    // is in flight until mclk echoes it back; later drops merge into it
    assign drop_pend = drop_tgl_r != ack_s_r[2];

    // The video source cannot be stalled; a full buffer drops the pixel
    always_ff @(posedge link_clk) begin
      if (!lrst_n_r) begin
        cap_valid_r <= 1'b0;
        cap_word_r  <= '0;
        drop_tgl_r  <= 1'b0;
        ack_s_r     <= '0;
      end else begin
        ack_s_r     <= {ack_s_r[1:0], drop_s_r[2]};
        cap_valid_r <= link_en;
        if (link_en) begin
          cap_word_r <= '{frame_sync: link_frame, line_sync: link_line,
                          chan_c: pins[p].chan_c, chan_b: pins[p].chan_b,
                          chan_a: pins[p].chan_a};
        end
        if (cap_valid_r && !cap_ready && !drop_pend) begin
          drop_tgl_r <= ~drop_tgl_r;
        end
      end
    end

    pixel_fifo #(
      .WIDTH ($bits(pixel_word_type)),
      .DEPTH (FIFO_DEPTH),
      .SYNC  (SYNC_STAGES)
    ) u_fifo (
      .wr_clk   (link_clk),
      .wr_rst_n (lrst_n_r),
      .wr_valid (cap_valid_r),
      .wr_ready (cap_ready),
      .wr_data  (cap_word_r),
      .rd_clk   (mclk),
      .rd_rst_n (rst_n),
      .rd_valid (pixel_out_valid[p]),
      .rd_ready (pixel_out_ready[p]),
      .rd_data  (fifo_word)
    );
    assign pixel_out[p] = fifo_word;

    // Drop events cross as a toggle; a set in the clearing cycle wins
    assign drop_seen = drop_s_r[1] != drop_s_r[2];
    assign ovf_nxt   = drop_seen || (ovf_r && !overflow_clear[p]);

    always_ff @(posedge mclk) begin
      if (!rst_n) begin
        drop_s_r <= '0;
        ovf_r    <= `PIX_OVF_RST;
      end else begin
        drop_s_r <= {drop_s_r[1:0], drop_tgl_r};
        ovf_r    <= ovf_nxt;
      end
    end
    assign overflow[p] = ovf_r;
  end

  // ********************************************************************
  // Autolock sync inputs
  // ********************************************************************
  // These never touch the pixel ports; they are only cleaned and timed
  autolock_type      al_raw;
  autolock_type      al_s1_r;
  autolock_type      al_s2_r;
  autolock_type      al_s3_r;
  autolock_type      al_lvl_r;
  autolock_type      al_rise_r;
  autolock_type      al_agree;
  autolock_type      al_lvl_nxt;

  assign al_raw = '{frame_sync: autolock_frame_sync, line_sync: autolock_line_sync,
                    composite_sync: autolock_composite_sync};
  assign al_agree   = ~(al_s2_r ^ al_s3_r);
  assign al_lvl_nxt = (al_agree & al_s3_r) | (~al_agree & al_lvl_r);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      al_s1_r   <= {3{`PIX_SYNC_RST}};
      al_s2_r   <= {3{`PIX_SYNC_RST}};
      al_s3_r   <= {3{`PIX_SYNC_RST}};
      al_lvl_r  <= {3{`PIX_SYNC_RST}};
      al_rise_r <= '0;
    end else begin
      al_s1_r   <= al_raw;
      al_s2_r   <= al_s1_r;
      al_s3_r   <= al_s2_r;
      al_lvl_r  <= al_lvl_nxt;
      al_rise_r <= al_lvl_nxt & ~al_lvl_r;
    end
  end

  assign autolock_sync = al_lvl_r;
  assign autolock_rise = al_rise_r;
endmodule

/* design/pixel_fifo.sv */
// Dual-clock pixel FIFO with gray-coded pointers and registered read data
`timescale 1ns/1ps
`include "pixin_defs.svh"

module pixel_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = `PIX_FIFO_DEPTH,
  parameter int SYNC  = `PIX_SYNC_STAGES
) (
  input  wire logic             wr_clk,
  input  wire logic             wr_rst_n,
  input  wire logic             wr_valid,
  output logic                  wr_ready,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic             rd_clk,
  input  wire logic             rd_rst_n,
  output logic                  rd_valid,
  input  wire logic             rd_ready,
  output logic [WIDTH-1:0]      rd_data
);
  localparam int AW = $clog2(DEPTH);

  function automatic logic [AW:0] to_gray(input logic [AW:0] b);
    return b ^ (b >> 1);
  endfunction

  logic [WIDTH-1:0]       mem [DEPTH];
  logic [AW:0]            wbin_r;
  logic [AW:0]            wgray_r;
  logic [AW:0]            rbin_r;
  logic [AW:0]            rgray_r;
  logic [SYNC-1:0][AW:0]  rgray_s_r;
  logic [SYNC-1:0][AW:0]  wgray_s_r;
  logic                   rd_valid_r;
  logic [WIDTH-1:0]       rd_data_r;
  logic [AW:0]            wbin_nxt;
  logic [AW:0]            rbin_nxt;
  logic                   push;
  logic                   pop;
  logic                   empty;

  // ********************************************************************
  // Write side
  // ********************************************************************
  // Full is judged on a delayed read pointer, so it is pessimistic only
  assign wr_ready = wgray_r != {~rgray_s_r[SYNC-1][AW:AW-1], rgray_s_r[SYNC-1][AW-2:0]};
  assign push     = wr_valid && wr_ready;
  assign wbin_nxt = wbin_r + {{AW{1'b0}}, 1'b1};

  always_ff @(posedge wr_clk) begin
    if (!wr_rst_n) begin
      wbin_r    <= '0;
      wgray_r   <= '0;
      rgray_s_r <= '0;
    end else begin
      rgray_s_r <= {rgray_s_r[SYNC-2:0], rgray_r};
      if (push) begin
        wbin_r  <= wbin_nxt;
        wgray_r <= to_gray(wbin_nxt);
      end
    end
  end

  always_ff @(posedge wr_clk) begin
    if (push) begin
      mem[wbin_r[AW-1:0]] <= wr_data;
    end
  end

  // ********************************************************************
  // Read side
  // ********************************************************************
  assign empty    = rgray_r == wgray_s_r[SYNC-1];
  assign pop      = !empty && (!rd_valid_r || rd_ready);
  assign rbin_nxt = rbin_r + {{AW{1'b0}}, 1'b1};
  assign rd_valid = rd_valid_r;
  assign rd_data  = rd_data_r;

  always_ff @(posedge rd_clk) begin
    if (!rd_rst_n) begin
      rbin_r     <= '0;
      rgray_r    <= '0;
      wgray_s_r  <= '0;
      rd_valid_r <= 1'b0;
      rd_data_r  <= '0;
    end else begin
      wgray_s_r <= {wgray_s_r[SYNC-2:0], wgray_r};
      if (pop) begin
        rbin_r     <= rbin_nxt;
        rgray_r    <= to_gray(rbin_nxt);
        rd_data_r  <= mem[rbin_r[AW-1:0]];
        rd_valid_r <= 1'b1;
      end else if (rd_ready) begin
        rd_valid_r <= 1'b0;
      end
    end
  end
endmodule

/* design/pixin_defs.svh */
// Shared constants of the dual-port pixel input block
`ifndef PIXIN_DEFS_SVH
`define PIXIN_DEFS_SVH

// ********************************************************************
// Pixel format
// ********************************************************************
// Channel word is unsigned fixed point: bit 9 weighs 128, bit 0 weighs 0.25
`define PIX_CHAN_W       10
`define PIX_FRAC_BITS    2
`define PIX_PORTS        2
`define PIX_CLOCKS       3
`define PIX_VALIDS       2

// ********************************************************************
// Buffering and crossing
// ********************************************************************
`define PIX_FIFO_DEPTH   4
`define PIX_SYNC_STAGES  3

// ********************************************************************
// Reset values
// ********************************************************************
`define PIX_OVF_RST      1'b0
`define PIX_SYNC_RST     1'b0

`endif

/* design/pixin_pkg.sv */
// Types shared by the pixel input block, its checker and its bench
package pixin_pkg;
  `include "pixin_defs.svh"

  typedef logic [`PIX_CHAN_W-1:0] chan_type;

  // Which input port a clock or a data enable serves
  typedef enum logic [1:0] {
    ROUTE_PORT1,
    ROUTE_PORT2,
    ROUTE_BOTH
  } route_type;

  typedef struct packed {
    logic     frame_sync;
    logic     line_sync;
    chan_type chan_c;
    chan_type chan_b;
    chan_type chan_a;
  } pixel_word_type;

  typedef struct packed {
    chan_type chan_c;
    chan_type chan_b;
    chan_type chan_a;
  } pixel_pins_type;

  typedef struct packed {
    logic frame_sync;
    logic line_sync;
    logic composite_sync;
  } autolock_type;
endpackage

/* tb/dual_port_pixel_input_checker.sv */
// Port-level assertions for the dual-port pixel input
`timescale 1ns/1ps
`include "pixin_defs.svh"

module dual_port_pixel_input_checker
  import pixin_pkg::*;
(
  input wire logic                                  mclk,
  input wire logic                                  rst_n,
  input wire pixin_pkg::route_type                  clk_route_1,
  input wire pixin_pkg::route_type                  clk_route_2,
  input wire pixin_pkg::route_type                  clk_route_3,
  input wire pixin_pkg::pixel_word_type [`PIX_PORTS-1:0] pixel_out,
  input wire logic [`PIX_PORTS-1:0]                 pixel_out_valid,
  input wire logic [`PIX_PORTS-1:0]                 pixel_out_ready,
  input wire logic [`PIX_PORTS-1:0]                 port_clocked,
  input wire logic [`PIX_PORTS-1:0]                 overflow,
  input wire logic [`PIX_PORTS-1:0]                 overflow_clear,
  input wire logic                                  autolock_line_sync,
  input wire logic                                  autolock_composite_sync,
  input wire pixin_pkg::autolock_type               autolock_sync,
  input wire pixin_pkg::autolock_type               autolock_rise
);
  import pixin_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence stall0_s; pixel_out_valid[0] && !pixel_out_ready[0]; endsequence
  sequence kept0_s; pixel_out_valid[0] && $stable(pixel_out[0]); endsequence
  sequence stall1_s; pixel_out_valid[1] && !pixel_out_ready[1]; endsequence
  sequence kept1_s; pixel_out_valid[1] && $stable(pixel_out[1]); endsequence

  a_hold_port1: assert property (stall0_s |=> kept0_s)
    else $error("port1 pixel changed while stalled");
  a_hold_port2: assert property (stall1_s |=> kept1_s)
    else $error("port2 pixel changed while stalled");
  a_clock_route1: assert property (port_clocked[0] == (clk_route_1 != ROUTE_PORT2 ||
    clk_route_2 != ROUTE_PORT2 || clk_route_3 != ROUTE_PORT2)) else $error("port1 clock flag");
  a_clock_route2: assert property (port_clocked[1] == (clk_route_1 != ROUTE_PORT1 ||
    clk_route_2 != ROUTE_PORT1 || clk_route_3 != ROUTE_PORT1)) else $error("port2 clock flag");
  a_overflow_sticky: assert property (overflow[0] && !overflow_clear[0] |=> overflow[0])
    else $error("overflow lost without clear");
  a_clear_cause: assert property ($fell(overflow[0]) |-> $past(overflow_clear[0]))
    else $error("overflow fell without clear");
  a_rise_pulse: assert property (autolock_rise.frame_sync == $rose(autolock_sync.frame_sync))
    else $error("frame rise pulse mismatch");
  a_line_lag: assert property ($rose(autolock_sync.line_sync) |-> $past(autolock_line_sync, 4))
    else $error("line sync rose too early");
  a_comp_lag: assert property ($fell(autolock_sync.composite_sync) |->
    !$past(autolock_composite_sync, 4) && !autolock_rise.composite_sync) else $error("comp sync");
endmodule

bind dual_port_pixel_input dual_port_pixel_input_checker chk_u (.mclk, .rst_n, .clk_route_1,
  .clk_route_2, .clk_route_3, .pixel_out, .pixel_out_valid, .pixel_out_ready, .port_clocked,
  .overflow, .overflow_clear, .autolock_line_sync, .autolock_composite_sync, .autolock_sync,
  .autolock_rise);

/* tb/dual_port_pixel_input_test.sv */
// Self-checking bench for the dual-port pixel input
`timescale 1ns/1ps

module dual_port_pixel_input_test;
  import pixin_pkg::*;
  logic           mclk, rst_n, lclk, den, fsync, lsync, clk_all, en2;
  logic [1:0]     clk_sel, to_other, ready, ovf_clr, vout, clocked, ovf;
  logic [2:0]     falling, wclk, al_in;
  route_type      cr1, cr2, cr3, vr1, vr2;
  pixel_pins_type pins;
  pixel_word_type [1:0] pout;
  autolock_type   al_sync, al_rise;
  int             errors, n_checks, cycles;

  // Unselected link clocks stand still; all run while in reset
  assign wclk = clk_all ? {3{lclk}} : (3'(lclk) << clk_sel);

  pixel_source src_u (.fall(falling[clk_sel]), .lclk(lclk), .den(den), .pins(pins),
    .fsync(fsync), .lsync(lsync));

  dual_port_pixel_input dut_u (.mclk(mclk), .rst_n(rst_n), .pixel_write_clock_1(wclk[0]),
    .pixel_write_clock_2(wclk[1]), .pixel_write_clock_3(wclk[2]), .pixel_valid_1(den),
    .pixel_valid_2(den & en2), .port1_pins(pins), .port2_pins(pins),
    .port1_frame_sync(fsync), .port1_line_sync(lsync), .port2_frame_sync(1'b0),
    .port2_line_sync(1'b0), .autolock_frame_sync(al_in[2]), .autolock_line_sync(al_in[1]),
    .autolock_composite_sync(al_in[0]), .clk_falling_edge(falling), .clk_route_1(cr1),
    .clk_route_2(cr2), .clk_route_3(cr3), .valid_route_1(vr1), .valid_route_2(vr2),
    .sync_to_other(to_other), .pixel_out(pout), .pixel_out_valid(vout),
    .pixel_out_ready(ready), .port_clocked(clocked), .overflow(ovf),
    .overflow_clear(ovf_clr), .autolock_sync(al_sync), .autolock_rise(al_rise));

  // ********************************************************************
  // Helpers
  // ********************************************************************
  task automatic tick;
    @(posedge mclk);
    #5;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  function automatic pixel_word_type px(input int i, input logic fs, input logic ls);
    return {fs, ls, 10'h3c0 ^ 10'(i), 10'h201 + 10'(i), 10'h155 ^ 10'(i)};
  endfunction

  task automatic take(input int p, input pixel_word_type exp);
    int n;
    n = 0;
    while (vout[p] !== 1'b1 && n < 300) begin
      tick();
      n++;
    end
    check("pixel_out", exp, pout[p]);
    ready[p] = 1'b1;
    tick();
    ready[p] = 1'b0;
  endtask

  task automatic end_sim;
    if (errors == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      end_sim();
    end
  end

  // ********************************************************************
  // Scenarios
  // ********************************************************************
  initial begin
    {rst_n, clk_all, clk_sel, falling, en2, to_other, ready, ovf_clr, al_in} = '0;
    clk_all = 1'b1;
    cr1 = ROUTE_PORT1;
    vr1 = ROUTE_PORT1;
    cr2 = ROUTE_PORT2;
    cr3 = ROUTE_PORT2;
    vr2 = ROUTE_PORT2;
    {errors, n_checks, cycles} = '0;
    fork
      src_u.send(12, 1'b0);
      repeat (20) tick();
    join
    rst_n = 1'b1;
    src_u.send(2, 1'b0);
    clk_all = 1'b0;
    // Every clock and both edges in turn, others parked on port2
    for (int k = 0; k < 3; k++) begin
      for (int e = 0; e < 2; e++) begin
        clk_sel = 2'(k);
        falling = e ? 3'b111 : 3'b000;
        cr1 = (k == 0) ? ROUTE_PORT1 : ROUTE_PORT2;
        cr2 = (k == 1) ? ROUTE_PORT1 : ROUTE_PORT2;
        cr3 = (k == 2) ? ROUTE_PORT1 : ROUTE_PORT2;
        tick();
        check("port_clocked", 2'b11, clocked);
        src_u.send(3, 1'b1);
        for (int i = 0; i < 3; i++) take(0, px(i, i == 0, 1'b1));
      end
    end
    {clk_sel, falling} = {2'd0, 3'b000};
    cr1 = ROUTE_BOTH;
    cr2 = ROUTE_PORT1;
    cr3 = ROUTE_PORT1;
    vr1 = ROUTE_BOTH;
    vr2 = ROUTE_PORT2;
    to_other = 2'b01;
    tick();
    check("port_clocked", 2'b11, clocked);
    src_u.send(2, 1'b1);
    for (int i = 0; i < 2; i++) begin
      take(0, px(i, 1'b0, 1'b0));
      take(1, px(i, i == 0, 1'b1));
    end
    vr1 = ROUTE_PORT1;
    {en2, to_other} = 3'b000;
    src_u.send(2, 1'b1);
    for (int i = 0; i < 2; i++) take(0, px(i, i == 0, 1'b1));
    repeat (20) tick();
    check("pixel_out_valid", 1'b0, vout[1]);
    src_u.send(8, 1'b1);
    repeat (10) tick();
    check("overflow", 2'b01, ovf);
    for (int i = 0; i < 4; i++) take(0, px(i, i == 0, 1'b1));
    ready[0] = 1'b1;
    repeat (10) tick();
    {ready[0], ovf_clr[0]} = 2'b01;
    tick();
    ovf_clr[0] = 1'b0;
    tick();
    check("overflow", 2'b00, ovf);
    foreach (al_in[j]) begin
      al_in = 3'b001 << j;
      repeat (8) tick();
      check("autolock_sync", 3'b001 << j, al_sync);
    end
    al_in = 3'b000;
    repeat (8) tick();
    check("autolock_sync", 3'b000, al_sync);
    end_sim();
  end
endmodule

/* tb/pixel_source.sv */
// Behavioural video source for the pixel input ports
`timescale 1ns/1ps

module pixel_source
  import pixin_pkg::*;
(
  input  wire logic                fall,
  output logic                     lclk,
  output logic                     den,
  output pixin_pkg::pixel_pins_type pins,
  output logic                     fsync,
  output logic                     lsync
);
  import pixin_pkg::*;
  pixel_pins_type word;

  initial begin
    lclk = 1'b0;
    den = 1'b0;
    pins = '1;
    fsync = 1'b0;
    lsync = 1'b0;
  end

  // ********************************************************************
  // Frame of n pixels
  // ********************************************************************
  // Leading idle edges let the buffer's read pointer cross back first.
  // Data is held only around the chosen edge; the other edge sees it inverted.
  task automatic send(input int n, input logic en);
    for (int i = -5; i < n + 2; i++) begin
      word = {10'h3c0 ^ 10'(i), 10'h201 + 10'(i), 10'h155 ^ 10'(i)};
      den = en && i >= 0 && i < n;
      fsync = en && i == 0;
      lsync = en && i >= 0 && i < n;
      pins = (!fall && i >= 0 && i < n) ? word : ~word;
      #7.5 lclk = 1'b1;
      #7.5 pins = (fall && i >= 0 && i < n) ? word : ~word;
      #7.5 lclk = 1'b0;
      #7.5;
    end
  endtask
endmodule
